// File: logic/flash_prog_dev.sv
// Device end: decodes buffer program commands, holds two page buffers and runs
// the self-timed erase/program sequence out through a two-entry record buffer.
// Assumes link pins are synchronous to clk_sys_i; main memory sits on the mem port.
`timescale 1ns/10ps

// Notes on behaviour
// (R1) 528 mode: 88h/89h, page bits, dummy rest
// (R2) 512 mode: 88h/89h, three dummy, page, nine dummy
// (R3) Select rise programs chosen buffer into page
// (R4) Host pre-erases page before no-erase program
// (R5) Busy shown throughout the page program
// (R6) Failed byte verify sets program error flag
// (R7) 528 mode: 82h/85h carry page and buffer offset
// (R8) 512 mode: 82h/85h carry page and offset
// (R9) Data bytes fill buffer from offset, wrapping
// (R10) 82h/85h erase page first, then program
// (R11) 528 mode: 02h writes buffer 1, wraps
// (R12) 512 mode: 02h accepts up to 512 bytes
// (R13) 512 mode: page and offset form linear address
// (R14) 02h programs only received byte positions
// (R15) Mid-byte select rise aborts, programs nothing
// (R16) 02h busy time scales with byte count
// (R17) MSB first, sampled on clock rise, select low
module flash_prog_dev
    import flash_prog_pkg::*;
#(
    parameter int BYTE_CYC  = BYTE_PROG_CYC,
    parameter int PAGE_CYC  = PAGE_PROG_CYC,
    parameter int ERASE_CNT = ERASE_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    spi_link_if.dev          link,
    input  wire logic        mode_bin_i,
    output logic             ready_o,
    output logic             epe_o,
    output logic             mem_valid_o,
    input  wire logic        mem_ready_i,
    output logic             mem_erase_o,
    output logic [21:0]      mem_addr_o,
    output logic [7:0]       mem_data_o,
    input  wire logic        mem_fail_i
);
    if (BYTE_CYC < 1 || ERASE_CNT < 1 || BYTE_CYC * PAGE_STD > PAGE_CYC) begin : g_bad_par
        $error("cycle counts zero or byte time exceeds page time");
    end

    localparam int TW = $clog2((BYTE_CYC > ERASE_CNT ? BYTE_CYC : ERASE_CNT) + 1);

    function automatic logic [9:0] wrap_col(input logic [9:0] a, input logic [9:0] b,
                                            input logic [9:0] size);
        logic [10:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, size}) begin
            s = s - {1'b0, size};
        end
        return s[9:0];
    endfunction : wrap_col

    // Page and column to memory address; binary mode yields one linear address
    function automatic logic [21:0] mem_addr(input logic bin, input logic [11:0] page,
                                             input logic [9:0] col);
        return bin ? {1'b0, page, col[8:0]} : {page, col}; // (R13)
    endfunction : mem_addr

    // Serial side
    logic        sck_q_r;
    logic        cs_q_r;
    logic [7:0]  shift_r;
    logic [2:0]  bit_r;
    logic [2:0]  byte_r;
    logic [7:0]  op_r;
    logic [23:0] adr_r;
    logic [9:0]  ptr_r;
    logic [9:0]  cnt_r;
    logic [7:0]  buf_mem [2][PAGE_STD];

    // Engine side
    dev_state_e  est_r;
    logic [TW-1:0] tmr_r;
    logic        ebin_r;
    logic        esel_r;
    logic [11:0] epage_r;
    logic [9:0]  eoff_r;
    logic [9:0]  en_r;
    logic [9:0]  eidx_r;
    logic        epe_r;

    // Record buffer
    logic [REC_W-1:0] fifo_q [2];
    logic        wp_r;
    logic        rp_r;
    logic [1:0]  fcnt_r;

    logic        busy;
    logic        rise;
    logic        cs_rise;
    logic [7:0]  nbyte;
    logic        byte_done;
    logic        is_data_op;
    logic        is_valid_op;
    logic [23:0] adr_nxt;
    logic [9:0]  psize;
    logic        launch;
    logic        tmr_done;
    logic        push;
    logic [REC_W-1:0] push_rec;
    logic        pop;
    logic [9:0]  ecol;

    assign busy        = (est_r != E_IDLE);
    assign rise        = link.sck && !sck_q_r && !link.cs_n; // (R17)
    assign cs_rise     = link.cs_n && !cs_q_r;
    assign nbyte       = {shift_r[6:0], link.si}; // (R17)
    assign byte_done   = rise && (bit_r == 3'h7) && !busy;
    assign is_data_op  = (op_r == OP_ERPROG_B1) || (op_r == OP_ERPROG_B2)
                         || (op_r == OP_BYTE_PROG);
    assign is_valid_op = is_data_op || (op_r == OP_PROG_B1) || (op_r == OP_PROG_B2);
    assign adr_nxt     = {adr_r[15:0], nbyte};
    assign psize       = mode_bin_i ? PAGE_BIN_W : PAGE_STD_W;
    // Only a whole-byte frame with a full address starts an operation
    assign launch      = cs_rise && !busy && (bit_r == 3'h0) && (byte_r == 3'(ADDR_BYTES + 1))
                         && is_valid_op && (op_r != OP_BYTE_PROG || cnt_r != 10'h0); // (R15)
    assign ready_o     = !busy; // (R5)
    assign epe_o       = epe_r;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sck_q_r <= 1'b0;
            cs_q_r  <= 1'b1;
        end else begin
            sck_q_r <= link.sck;
            cs_q_r  <= link.cs_n;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            shift_r <= 8'h00;
            bit_r   <= 3'h0;
            byte_r  <= 3'h0;
            op_r    <= 8'h00;
            adr_r   <= 24'h000000;
            ptr_r   <= 10'h000;
            cnt_r   <= 10'h000;
        end else if (link.cs_n) begin
            bit_r  <= 3'h0;
            byte_r <= 3'h0;
            cnt_r  <= 10'h000;
        end else if (rise && !busy) begin
            shift_r <= nbyte;
            bit_r   <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                if (byte_r == 3'h0) begin
                    op_r <= nbyte;
                end else if (byte_r <= 3'(ADDR_BYTES)) begin
                    adr_r <= adr_nxt; // (R1) (R2) (R7) (R8) (R11) (R12)
                    ptr_r <= mode_bin_i ? {1'b0, adr_nxt[8:0]} : adr_nxt[9:0];
                end else if (is_data_op) begin
                    ptr_r <= wrap_col(ptr_r, 10'h001, psize); // (R9) (R11) (R12)
                    if (cnt_r != psize) begin
                        cnt_r <= cnt_r + 10'h001; // (R14)
                    end
                end
                if (byte_r != 3'(ADDR_BYTES + 1)) begin
                    byte_r <= byte_r + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (byte_done && byte_r == 3'(ADDR_BYTES + 1) && is_data_op) begin
            buf_mem[op_r == OP_ERPROG_B2][ptr_r] <= nbyte; // (R9)
        end
    end

    assign tmr_done = (est_r == E_ERASE) ? (tmr_r >= TW'(ERASE_CNT - 1))
                                         : (tmr_r >= TW'(BYTE_CYC - 1));
    assign ecol     = wrap_col(eoff_r, eidx_r, ebin_r ? PAGE_BIN_W : PAGE_STD_W);
    assign push     = (est_r == E_ERASE || est_r == E_PROG) && tmr_done && (fcnt_r != 2'h2);
    assign push_rec = (est_r == E_ERASE)
                      ? {1'b1, mem_addr(ebin_r, epage_r, 10'h000), 8'hFF} // (R10)
                      : {1'b0, mem_addr(ebin_r, epage_r, ecol), buf_mem[esel_r][ecol]};

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            est_r   <= E_IDLE;
            tmr_r   <= '0;
            ebin_r  <= 1'b0;
            esel_r  <= 1'b0;
            epage_r <= 12'h000;
            eoff_r  <= 10'h000;
            en_r    <= 10'h000;
            eidx_r  <= 10'h000;
        end else begin
            case (est_r)
                E_IDLE: begin
                    if (launch) begin // (R3)
                        ebin_r  <= mode_bin_i;
                        esel_r  <= (op_r == OP_PROG_B2) || (op_r == OP_ERPROG_B2);
                        epage_r <= mode_bin_i ? adr_r[20:9] : adr_r[21:10];
                        eidx_r  <= 10'h000;
                        tmr_r   <= '0;
                        if (op_r == OP_BYTE_PROG) begin
                            eoff_r <= mode_bin_i ? {1'b0, adr_r[8:0]} : adr_r[9:0]; // (R14)
                            en_r   <= cnt_r; // (R16)
                            est_r  <= E_PROG;
                        end else begin
                            eoff_r <= 10'h000;
                            en_r   <= psize;
                            est_r  <= (op_r == OP_ERPROG_B1 || op_r == OP_ERPROG_B2)
                                      ? E_ERASE : E_PROG; // (R10)
                        end
                    end
                end
                E_ERASE: begin
                    if (!tmr_done) begin
                        tmr_r <= tmr_r + TW'(1);
                    end else if (push) begin
                        tmr_r <= '0;
                        est_r <= E_PROG;
                    end
                end
                E_PROG: begin
                    // One record per byte time, so busy scales with the count
                    if (!tmr_done) begin
                        tmr_r <= tmr_r + TW'(1); // (R16)
                    end else if (push) begin
                        tmr_r  <= '0;
                        eidx_r <= eidx_r + 10'h001;
                        if (eidx_r == en_r - 10'h001) begin
                            est_r <= E_DRAIN;
                        end
                    end
                end
                E_DRAIN: begin
                    if (fcnt_r == 2'h0) begin
                        est_r <= E_IDLE; // (R5)
                    end
                end
                default: begin
                    est_r <= E_IDLE;
                end
            endcase
        end
    end

    // Error flag clears when a new operation starts; the buffer is then empty
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            epe_r <= 1'b0;
        end else if (pop && mem_fail_i) begin
            epe_r <= 1'b1; // (R6)
        end else if (launch) begin
            epe_r <= 1'b0;
        end
    end

    assign pop         = (fcnt_r != 2'h0) && mem_ready_i;
    assign mem_valid_o = (fcnt_r != 2'h0);
    assign {mem_erase_o, mem_addr_o, mem_data_o} = fifo_q[rp_r];

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wp_r   <= 1'b0;
            rp_r   <= 1'b0;
            fcnt_r <= 2'h0;
            fifo_q <= '{default: '0};
        end else begin
            if (push) begin
                fifo_q[wp_r] <= push_rec;
                wp_r         <= !wp_r;
            end
            if (pop) begin
                rp_r <= !rp_r;
            end
            fcnt_r <= fcnt_r + 2'(push) - 2'(pop);
        end
    end

endmodule : flash_prog_dev

// File: logic/flash_prog_host.sv
// Host end: shifts opcode, three address bytes and optional data bytes out.
// Assumes the user side keeps a command stable while cmd_valid_i is high.
`timescale 1ns/10ps
module flash_prog_host
    import flash_prog_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    spi_link_if.host         link,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [7:0]  cmd_op_i,
    input  wire logic [23:0] cmd_addr_i,
    input  wire logic        cmd_data_i,
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        wr_last_i
);
    if (HALF_CYC < 1) begin : g_bad_half
        $error("HALF_CYC must be at least 1");
    end

    localparam int TW = $clog2(HALF_CYC + 1);

    host_state_e    st_r;
    logic [TW-1:0]  div_r;
    logic           tick;
    logic           cs_n_r;
    logic           sck_r;
    logic [7:0]     sh_r;
    logic [23:0]    hdr_r;
    logic [1:0]     hdr_cnt_r;
    logic [2:0]     bit_r;
    logic           data_r;
    logic           last_r;

    assign tick        = (div_r == TW'(HALF_CYC - 1));
    assign cmd_ready_o = (st_r == H_IDLE);
    assign wr_ready_o  = (st_r == H_FETCH);
    assign link.cs_n   = cs_n_r;
    assign link.sck    = sck_r;
    assign link.si     = sh_r[7]; // (R17)

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + TW'(1);
        end
    end

    // Bits change while the clock is low, the device samples on the rise
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_r      <= H_IDLE;
            cs_n_r    <= 1'b1;
            sck_r     <= 1'b0;
            sh_r      <= 8'h00;
            hdr_r     <= 24'h000000;
            hdr_cnt_r <= 2'h0;
            bit_r     <= 3'h0;
            data_r    <= 1'b0;
            last_r    <= 1'b0;
        end else begin
            case (st_r)
                H_IDLE: begin
                    if (cmd_valid_i) begin
                        sh_r      <= cmd_op_i;
                        hdr_r     <= cmd_addr_i; // (R1) (R2) (R7) (R8) (R11) (R12)
                        hdr_cnt_r <= 2'(ADDR_BYTES);
                        data_r    <= cmd_data_i;
                        last_r    <= 1'b0;
                        bit_r     <= 3'h0;
                        cs_n_r    <= 1'b0; // (R17)
                        st_r      <= H_BIT;
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        if (!sck_r) begin
                            sck_r <= 1'b1;
                        end else begin
                            sck_r <= 1'b0;
                            bit_r <= bit_r + 3'h1;
                            if (bit_r != 3'h7) begin
                                sh_r <= {sh_r[6:0], 1'b0};
                            end else if (hdr_cnt_r != 2'h0) begin
                                sh_r      <= hdr_r[23:16];
                                hdr_r     <= {hdr_r[15:0], 8'h00};
                                hdr_cnt_r <= hdr_cnt_r - 2'h1;
                            end else if (data_r && !last_r) begin
                                st_r <= H_FETCH;
                            end else begin
                                st_r <= H_END; // (R15)
                            end
                        end
                    end
                end
                H_FETCH: begin
                    if (wr_valid_i) begin
                        sh_r   <= wr_data_i;
                        last_r <= wr_last_i;
                        st_r   <= H_BIT;
                    end
                end
                H_END: begin
                    if (tick) begin
                        cs_n_r <= 1'b1;
                        st_r   <= H_IDLE;
                    end
                end
                default: begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end

endmodule : flash_prog_host

// File: logic/flash_prog_pkg.sv
// Opcodes, page geometry and timing for the buffered page program link.
// Assumes a 20 MHz system clock shared by both ends of the link.
package flash_prog_pkg;

    localparam logic [7:0]  OP_PROG_B1      = 8'h88;
    localparam logic [7:0]  OP_PROG_B2      = 8'h89;
    localparam logic [7:0]  OP_ERPROG_B1    = 8'h82;
    localparam logic [7:0]  OP_ERPROG_B2    = 8'h85;
    localparam logic [7:0]  OP_BYTE_PROG    = 8'h02;

    localparam int          PAGE_STD        = 528;
    localparam int          PAGE_BIN        = 512;
    localparam logic [9:0]  PAGE_STD_W      = 10'h210;
    localparam logic [9:0]  PAGE_BIN_W      = 10'h200;
    localparam int          ADDR_BYTES      = 3;
    localparam int          REC_W           = 31;

    localparam int          CLK_NS          = 50;
    localparam int          T_BP_NS         = 4000;
    localparam int          T_P_NS          = 2112000;
    localparam int          T_ERASE_NS      = 100000;
    localparam int          T_EP_NS         = T_P_NS + T_ERASE_NS;
    localparam int          BYTE_PROG_CYC   = T_BP_NS / CLK_NS;
    localparam int          PAGE_PROG_CYC   = T_P_NS / CLK_NS;
    localparam int          ERASE_CYC       = (T_EP_NS - T_P_NS) / CLK_NS;
    localparam int          SCK_HALF_CYC    = 2;

    typedef enum logic [1:0] {E_IDLE, E_ERASE, E_PROG, E_DRAIN} dev_state_e;
    typedef enum logic [1:0] {H_IDLE, H_BIT, H_FETCH, H_END} host_state_e;

endpackage : flash_prog_pkg

// File: logic/spi_link_if.sv
// Serial link between host controller and flash device: select, clock, data in.
// Assumes both ends run on the same system clock; the bench resolves nothing.
`timescale 1ns/10ps
interface spi_link_if;
    logic cs_n;
    logic sck;
    logic si;

    modport host (output cs_n, output sck, output si);
    modport dev  (input cs_n, input sck, input si);
endinterface : spi_link_if

// File: test/flash_prog_checker.sv
// Checker for the serial link and the device record port.
// Assumes one clock domain; instanced beside the link interface.
`timescale 1ns/10ps
module flash_prog_checker (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    input  wire logic        ready_o,
    input  wire logic        epe_o,
    input  wire logic        mem_valid_o,
    input  wire logic        mem_ready_i,
    input  wire logic        mem_erase_o,
    input  wire logic [21:0] mem_addr_o,
    input  wire logic [7:0]  mem_data_o,
    input  wire logic        mem_fail_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_sck_idle; cs_n |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("sck toggles outside a frame");
    property p_si_hold; sck && $past(sck) |-> $stable(si); endproperty
    a_si_hold: assert property (p_si_hold)
        else $error("si moved while sck high");
    property p_sck_high; $rose(sck) |-> sck [*2] ##1 !sck; endproperty
    a_sck_high: assert property (p_sck_high)
        else $error("sck high phase length wrong");
    property p_cs_rise; $rose(cs_n) |-> !$past(sck); endproperty
    a_cs_rise: assert property (p_cs_rise)
        else $error("select rose with sck high");
    property p_launch; $fell(ready_o) |-> cs_n; endproperty
    a_launch: assert property (p_launch)
        else $error("busy began inside a frame");
    property p_busy; mem_valid_o |-> !ready_o; endproperty
    a_busy: assert property (p_busy)
        else $error("record pending while ready");
    property p_epe_set; mem_valid_o && mem_ready_i && mem_fail_i |=> epe_o; endproperty
    a_epe_set: assert property (p_epe_set)
        else $error("failed byte did not set error flag");
    property p_epe_keep; epe_o && ready_o && cs_n |=> epe_o || !ready_o; endproperty
    a_epe_keep: assert property (p_epe_keep)
        else $error("error flag cleared while idle");
    property p_erase_rec;
        mem_valid_o && mem_erase_o |-> mem_data_o == 8'hFF && mem_addr_o[8:0] == 9'h000;
    endproperty
    a_erase_rec: assert property (p_erase_rec)
        else $error("erase record malformed");
    property p_rec_hold;
        mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o)
            && $stable(mem_data_o) && $stable(mem_erase_o);
    endproperty
    a_rec_hold: assert property (p_rec_hold)
        else $error("stalled record changed");
endmodule : flash_prog_checker

// File: test/test_buffered_page_program_cmds.sv
// Bench joining host and device ends, plus a rule-breaking raw driver.
// Assumes the package and spi_link_if are compiled first.
`timescale 1ns/10ps
module test_buffered_page_program_cmds;
    import flash_prog_pkg::*;
    logic             clk_sys_i, rst_n_i, cmd_valid_i, cmd_ready_o, cmd_data_i;
    logic             wr_valid_i, wr_ready_o, wr_last_i, mode_bin_i, ready_o, epe_o;
    logic             mem_valid_o, mem_ready_i, mem_erase_o, mem_fail_i, ready2, valid2;
    logic             epe2;
    logic [7:0]       cmd_op_i, wr_data_i, mem_data_o, data2;
    logic [23:0]      cmd_addr_i;
    logic [21:0]      mem_addr_o, addr2;
    logic [29:0]      rec2;
    logic [1:0]       stall_r;
    logic [7:0]       bufm [2][528];
    logic [REC_W-1:0] rq [$];
    int               n_pop, fail_idx, cnt2, busy_c, n_mismatch, compares;

    spi_link_if link ();
    spi_link_if link2 ();
    flash_prog_host flash_prog_host_inst (.clk_sys_i, .rst_n_i, .link, .cmd_valid_i,
        .cmd_ready_o, .cmd_op_i, .cmd_addr_i, .cmd_data_i, .wr_valid_i, .wr_ready_o,
        .wr_data_i, .wr_last_i);
    flash_prog_dev #(.BYTE_CYC(2), .ERASE_CNT(3), .PAGE_CYC(2000)) flash_prog_dev_inst (
        .clk_sys_i, .rst_n_i, .link, .mode_bin_i, .ready_o, .epe_o, .mem_valid_o,
        .mem_ready_i, .mem_erase_o, .mem_addr_o, .mem_data_o, .mem_fail_i);
    flash_prog_dev #(.BYTE_CYC(2), .ERASE_CNT(3), .PAGE_CYC(2000)) flash_prog_dev_inst2 (
        .clk_sys_i, .rst_n_i, .link(link2), .mode_bin_i, .ready_o(ready2),
        .epe_o(epe2), .mem_valid_o(valid2), .mem_ready_i(1'b1), .mem_erase_o(),
        .mem_addr_o(addr2), .mem_data_o(data2), .mem_fail_i);
    flash_prog_checker flash_prog_checker_inst (.clk_sys_i, .rst_n_i, .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .ready_o, .epe_o, .mem_valid_o, .mem_ready_i,
        .mem_erase_o, .mem_addr_o, .mem_data_o, .mem_fail_i);

    // Sink stalls one cycle in four; fail injected on a chosen record
    assign mem_ready_i = (stall_r != 2'h3);
    assign mem_fail_i  = (n_pop == fail_idx);

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        #1 stall_r = stall_r + 2'h1;
    end

    always @(posedge clk_sys_i) begin
        if (rst_n_i && mem_valid_o && mem_ready_i) begin
            rq.push_back({mem_erase_o, mem_addr_o, mem_data_o});
            n_pop <= n_pop + 1;
        end
        if (!ready_o) busy_c <= busy_c + 1;
        if (valid2) begin
            cnt2 <= cnt2 + 1;
            rec2 <= {addr2, data2};
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [21:0] addr_of(logic bin, logic [11:0] pg, logic [9:0] col);
        return bin ? {1'b0, pg, col[8:0]} : {pg, col};
    endfunction : addr_of

    task automatic do_cmd(logic [7:0] op, logic bin, logic [11:0] pg, logic [9:0] off, int n);
        int         sz;
        int         b;
        int         k;
        logic [9:0] col;
        sz = bin ? PAGE_BIN : PAGE_STD;
        b = (op == OP_ERPROG_B2 || op == OP_PROG_B2);
        rq.delete();
        @(posedge clk_sys_i) #1;
        n_pop = 0;
        busy_c = 0;
        mode_bin_i = bin;
        cmd_op_i = op;
        cmd_addr_i = bin ? {3'b111, pg, off[8:0]} : {2'b11, pg, off};
        cmd_data_i = (n > 0);
        cmd_valid_i = 1'b1;
        do @(posedge clk_sys_i); while (!cmd_ready_o);
        #1 cmd_valid_i = 1'b0;
        wr_valid_i = (n > 0);
        for (k = 0; k < n; k++) begin
            col = 10'((off + k) % sz);
            wr_data_i = op + 8'(k * 7);
            wr_last_i = (k == n - 1);
            do @(posedge clk_sys_i); while (!wr_ready_o);
            #1 bufm[b][col] = wr_data_i;
        end
        wr_valid_i = 1'b0;
        wait (link.cs_n === 1'b1);
        repeat (2) @(posedge clk_sys_i);
        #1 check("busy", ready_o, 1'b0);
        wait (ready_o === 1'b1);
        if (op == OP_ERPROG_B1 || op == OP_ERPROG_B2)
            check("erase rec", rq.pop_front(), {1'b1, addr_of(bin, pg, 10'h000), 8'hFF});
        check("rec count", rq.size(), (op == OP_BYTE_PROG) ? n : sz);
        foreach (rq[i]) begin
            col = (op == OP_BYTE_PROG) ? 10'((off + i) % sz) : 10'(i);
            check("rec addr", rq[i][30:8], {1'b0, addr_of(bin, pg, col)});
            if (^bufm[b][col] !== 1'bx) check("rec data", rq[i][7:0], bufm[b][col]);
        end
    endtask : do_cmd

    task automatic raw_frame(logic [39:0] v, int nb);
        @(posedge clk_sys_i) #1 link2.cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            link2.si = v[39 - i];
            repeat (2) @(posedge clk_sys_i);
            #1 link2.sck = 1'b1;
            repeat (2) @(posedge clk_sys_i);
            #1 link2.sck = 1'b0;
        end
        repeat (2) @(posedge clk_sys_i);
        #1 link2.cs_n = 1'b1;
        link2.si = ~link2.si;
        repeat (40) @(posedge clk_sys_i);
    endtask : raw_frame

    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        rst_n_i = 1'b0; cmd_valid_i = 1'b0; cmd_op_i = 8'h00; cmd_addr_i = 24'h000000;
        cmd_data_i = 1'b0; wr_valid_i = 1'b0; wr_data_i = 8'h00; wr_last_i = 1'b0;
        mode_bin_i = 1'b0; link2.cs_n = 1'b1; link2.sck = 1'b0; link2.si = 1'b0;
        n_pop = 0; fail_idx = -1; cnt2 = 0; busy_c = 0; stall_r = 2'h0;
        n_mismatch = 0; compares = 0;
        repeat (16) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        raw_frame({OP_BYTE_PROG, 24'h000010, 8'h5A}, 35);
        check("abort ready", ready2, 1'b1);
        check("abort recs", cnt2, 0);
        raw_frame({OP_BYTE_PROG, 24'h000010, 8'h5A}, 40);
        check("whole recs", cnt2, 1);
        check("whole rec", rec2, {22'h000010, 8'h5A});
        check("whole epe", epe2, 1'b0);
        raw_frame({8'hA5, 24'h000010, 8'h5A}, 40);
        check("unknown op recs", cnt2, 1);
        check("unknown op ready", ready2, 1'b1);
        do_cmd(OP_ERPROG_B1, 1'b0, 12'h5A3, 10'h20E, 4);
        check("epe", epe_o, 1'b0);
        do_cmd(OP_PROG_B1, 1'b0, 12'h5A3, 10'h3FF, 0);
        check("page busy", busy_c >= 2 * PAGE_STD, 1'b1);
        do_cmd(OP_ERPROG_B2, 1'b1, 12'hC3C, 10'h1FE, 3);
        do_cmd(OP_PROG_B2, 1'b1, 12'h0F1, 10'h3FF, 0);
        fail_idx = 1;
        do_cmd(OP_BYTE_PROG, 1'b1, 12'h7E7, 10'h1FF, 2);
        check("epe", epe_o, 1'b1);
        fail_idx = -1;
        do_cmd(OP_BYTE_PROG, 1'b0, 12'hABC, 10'h20F, 1);
        check("epe", epe_o, 1'b0);
        check("byte busy", busy_c < 40, 1'b1);
        tally_and_finish();
    end
endmodule : test_buffered_page_program_cmds
